/* File: design/nvm_cfg_pkg.sv */
package nvm_cfg_pkg;
   // memory geometry
   localparam int WORDS = 128;
   localparam int AW = 7;
   localparam int DW = 16;
   // block one layout
   localparam logic [6:0] BLK1_FIRST = 7'h00;
   localparam logic [6:0] BLK1_KEY = 7'h08;
   localparam logic [6:0] BLK1_SUM = 7'h09;
   // block two layout
   localparam logic [6:0] BLK2_FIRST = 7'h0a;
   localparam logic [6:0] BLK2_KEY = 7'h74;
   localparam logic [6:0] BLK2_SUM = 7'h75;
   // unlock values as delivered
   localparam logic [15:0] BLK1_UNLOCK = 16'h5a51;
   localparam logic [15:0] BLK2_UNLOCK = 16'h5a52;
   localparam logic [15:0] SIG_INIT = 16'hffff;
   // word holding the oscillator trim (low byte)
   localparam logic [6:0] TRIM_ADDR = 7'h3a;
   // write timing
   localparam int WRITE_TIME_MS = 8;
   localparam int CLK_HZ = 10_000_000;
   localparam int WRITE_CYCLES = (WRITE_TIME_MS * CLK_HZ) / 1000;
   // code memory word
   localparam int CODE_DW = 16;
   localparam int CODE_CW = 22;
   // axi register byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_SIG = 8'h14;
   localparam logic [7:0] REG_LIMITS = 8'h18;
   localparam logic [7:0] REG_CODE = 8'h1c;
   localparam logic [7:0] REG_CODE_OUT = 8'h20;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // limit pair carried as max / min bytes
   typedef struct packed {
      logic [7:0] max;
      logic [7:0] min;
   } limit_pair_t;
   // code memory decode result
   typedef struct packed {
      logic [15:0] data;
      logic corrected;
      logic fatal;
   } code_result_t;
endpackage

/* File: design/code_ecc.sv */
// single error correct, double error detect for a code word
module code_ecc
   import nvm_cfg_pkg::*;
(
   input wire logic [21:0] code_word, // 16 data, 5 hamming, 1 overall parity
   output code_result_t result // corrected data and flags
);
   // hamming positions 1..21, data in non power of two slots
   function automatic logic [15:0] extract(input logic [20:0] w);
      logic [15:0] d;
      int k;
      d = '0;
      k = 0;
      for (int p = 1; p <= 21; p++) begin
         if ((p & (p - 1)) != 0) begin
            d[k] = w[p-1];
            k++;
         end
      end
      return d;
   endfunction
   logic [4:0] syn; // syndrome
   logic [20:0] fixed; // word after flip
   logic par; // overall parity check
   always_comb begin
      syn = '0;
      for (int p = 1; p <= 21; p++) begin
         if (code_word[p-1]) begin
            syn = syn ^ 5'(p);
         end
      end
      par = ^code_word;
      fixed = code_word[20:0];
      if (syn != 5'h00 && par && syn <= 5'd21) begin
         fixed[syn-1] = ~fixed[syn-1]; // single error, correctable (see R14)
      end
      result.data = extract(fixed);
      result.corrected = par;
      // nonzero syndrome with even parity means two flips (see R14)
      result.fatal = (syn != 5'h00 && !par) || (par && syn > 5'd21);
   end
endmodule

/* File: design/config_nvm_lock_crc.sv */
// Notes on behaviour
// R1 - 128 words of 16 bits stored
// R2 - access only in configuration mode; the signature walk here runs outside it as well
// R3 - block one 0x00-0x09, key 0x08, sum 0x09
// R4 - block two 0x0a-0x75, key 0x74, sum 0x75
// R5 - only delivered key value permits writes
// R6 - locking takes effect at next session
// R7 - programmer fixes checksum before leaving
// R8 - signature taps 15,14,12,3, starts all ones
// R9 - fold first word through key, ascending
// R10 - shift left, feedback bit0, xor data
// R11 - single byte low, pair first low
// R12 - limit max upper byte, min lower
// R13 - code memory errors corrected or detected
// R14 - one bit fixed, two bits reset
// R15 - trim loaded from memory at startup
// R16 - one clock drives all logic
// R17 - each write takes about 8 ms
//
// Chosen here: register access over AXI4-Lite and the register offsets.
module config_nvm_lock_crc
   import nvm_cfg_pkg::*;
#(
   parameter int WRITE_WAIT = WRITE_CYCLES // write busy cycles
)(
   input wire logic aclk, // single clock (see R16)
   input wire logic aresetn, // sync reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   output logic [7:0] osc_trim, // applied oscillator trim
   output logic trim_valid, // trim loaded
   output logic ecc_reset_req // uncorrectable code error
);
   // shared signature step, used for both block sums
   function automatic logic [15:0] sig_step(input logic [15:0] s, input logic [15:0] d);
      logic fb;
      fb = s[15] ^ s[14] ^ s[12] ^ s[3]; // see R8
      return {s[14:0], fb} ^ d; // see R10
   endfunction
   // which block holds an address, for the open-block check
   function automatic logic in_blk1(input logic [6:0] a);
      return a <= BLK1_SUM; // see R3
   endfunction
   function automatic logic in_blk2(input logic [6:0] a);
      return a >= BLK2_FIRST && a <= BLK2_SUM; // see R4
   endfunction
   typedef enum {S_BOOT, S_TRIM, S_IDLE, S_WRITE, S_SIG} state_t;
   state_t state; // main sequencer
   logic [15:0] mem [WORDS]; // configuration words (see R1)
   logic cfg_mode; // configuration session active
   logic blk1_open; // block one writable this session
   logic blk2_open; // block two writable this session
   logic [6:0] addr; // word address register
   logic [15:0] wdata; // word to write
   logic [15:0] rdata; // last word read
   logic [15:0] sig; // running signature
   logic [6:0] sig_ptr; // signature walk address
   logic sig_blk; // 0 = block one, 1 = block two
   logic sig_match; // stored sum equals computed
   logic [31:0] wcount; // write busy counter
   logic wr_refused; // last write was refused
   logic start_write; // software write pulse
   logic start_read; // software read pulse
   logic start_sig; // software signature pulse
   logic enter_cfg; // session entry pulse
   logic leave_cfg; // session exit pulse
   logic [21:0] code_word; // code word under check
   code_result_t code_res; // decoded code word
   limit_pair_t lim; // limit pair view of read word
   logic aw_hold, w_hold; // captured write channels
   logic [7:0] aw_addr; // captured write address
   logic [31:0] w_data; // captured write data
   logic [3:0] w_strb; // captured strobes
   logic do_write; // both halves present

   code_ecc u_ecc (
      .code_word(code_word),
      .result(code_res)
   );
   // limit pair: upper byte maximum, lower minimum (see R12)
   assign lim = limit_pair_t'(rdata);

   // write channel capture, either order
   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready = !w_hold && !s_axi_bvalid;
   assign do_write = aw_hold && w_hold && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_hold <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_hold <= 1'b0;
         end
      end
   end

   // write response, one cycle after both halves meet
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (aw_addr <= REG_CODE && aw_addr[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // register writes; control bits 0-4 are pulses, bit 5 sig_blk is held, busy blocks new commands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         start_write <= 1'b0;
         start_read <= 1'b0;
         start_sig <= 1'b0;
         enter_cfg <= 1'b0;
         leave_cfg <= 1'b0;
         addr <= 7'h00;
         wdata <= 16'h0000;
         code_word <= 22'h000000;
         sig_blk <= 1'b0;
      end else begin
         start_write <= 1'b0;
         start_read <= 1'b0;
         start_sig <= 1'b0;
         enter_cfg <= 1'b0;
         leave_cfg <= 1'b0;
         if (do_write) begin
            if (aw_addr == REG_CTRL && w_strb[0]) begin
               enter_cfg <= w_data[0];
               leave_cfg <= w_data[1];
               start_write <= w_data[2];
               start_read <= w_data[3];
               start_sig <= w_data[4];
               sig_blk <= w_data[5];
            end else if (aw_addr == REG_ADDR && w_strb[0] && state == S_IDLE) begin
               addr <= w_data[6:0];
            end else if (aw_addr == REG_WDATA && state == S_IDLE) begin
               if (w_strb[0]) wdata[7:0] <= w_data[7:0]; // first setting low (see R11)
               if (w_strb[1]) wdata[15:8] <= w_data[15:8]; // second setting high (see R11)
            end else if (aw_addr == REG_CODE) begin
               code_word <= w_data[21:0];
            end
         end
      end
   end

   // session state; keys sampled only on entry so locks wait (see R6)
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_mode <= 1'b0;
         blk1_open <= 1'b0;
         blk2_open <= 1'b0;
      end else if (enter_cfg && !cfg_mode && state == S_IDLE) begin
         cfg_mode <= 1'b1;
         blk1_open <= mem[BLK1_KEY] == BLK1_UNLOCK; // see R5
         blk2_open <= mem[BLK2_KEY] == BLK2_UNLOCK; // see R5
      end else if (leave_cfg && state == S_IDLE) begin
         cfg_mode <= 1'b0; // sums are the programmer's duty here (see R7)
      end
   end

   // sequencer: trim load, timed write, signature walk
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= S_BOOT;
         osc_trim <= 8'h00;
         trim_valid <= 1'b0;
         wcount <= 32'h0000_0000;
         wr_refused <= 1'b0;
         rdata <= 16'h0000;
         sig <= SIG_INIT;
         sig_ptr <= 7'h00;
         sig_match <= 1'b0;
      end else begin
         case (state)
            S_BOOT: begin
               state <= S_TRIM;
            end
            S_TRIM: begin
               osc_trim <= mem[TRIM_ADDR][7:0]; // see R15
               trim_valid <= 1'b1;
               state <= S_IDLE;
            end
            S_IDLE: begin
               if (start_write) begin
                  // accept only inside a session and an open block (see R2)
                  if (cfg_mode && ((in_blk1(addr) && blk1_open) ||
                                   (in_blk2(addr) && blk2_open))) begin
                     wr_refused <= 1'b0;
                     wcount <= 32'(WRITE_WAIT);
                     state <= S_WRITE;
                  end else begin
                     wr_refused <= 1'b1;
                  end
               end else if (start_read && cfg_mode) begin
                  rdata <= mem[addr]; // see R2
               end else if (start_sig) begin
                  sig <= SIG_INIT; // see R8
                  sig_ptr <= sig_blk ? BLK2_FIRST : BLK1_FIRST;
                  state <= S_SIG;
               end
            end
            S_WRITE: begin
               // erase and program take the full time (see R17)
               if (wcount <= 32'd1) begin
                  state <= S_IDLE;
               end else begin
                  wcount <= wcount - 32'd1;
               end
            end
            S_SIG: begin
               sig <= sig_step(sig, mem[sig_ptr]); // ascending walk (see R9)
               if (sig_ptr == (sig_blk ? BLK2_KEY : BLK1_KEY)) begin
                  sig_match <= sig_step(sig, mem[sig_ptr]) ==
                               mem[sig_blk ? BLK2_SUM : BLK1_SUM]; // see R9
                  state <= S_IDLE;
               end else begin
                  sig_ptr <= sig_ptr + 7'h01;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // commits at end of write time; no reset, so a delivered image can be preloaded
   always @(posedge aclk) begin
      if (state == S_WRITE && wcount <= 32'd1) begin
         mem[addr] <= wdata;
      end
   end

   // uncorrectable code error requests a reset (see R13)
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ecc_reset_req <= 1'b0;
      end else begin
         ecc_reset_req <= code_res.fatal; // see R14
      end
   end

   // read channel, data one cycle after address
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         if (s_axi_araddr == REG_CTRL) begin
            s_axi_rdata <= {26'h0, sig_blk, 5'h00};
         end else if (s_axi_araddr == REG_ADDR) begin
            s_axi_rdata <= {25'h0, addr};
         end else if (s_axi_araddr == REG_WDATA) begin
            s_axi_rdata <= {16'h0, wdata};
         end else if (s_axi_araddr == REG_RDATA) begin
            s_axi_rdata <= {16'h0, rdata};
         end else if (s_axi_araddr == REG_STATUS) begin
            s_axi_rdata <= {24'h0, trim_valid, code_res.corrected, wr_refused,
                            sig_match, blk2_open, blk1_open, state != S_IDLE, cfg_mode};
         end else if (s_axi_araddr == REG_SIG) begin
            s_axi_rdata <= {16'h0, sig};
         end else if (s_axi_araddr == REG_LIMITS) begin
            s_axi_rdata <= {16'h0, lim.max, lim.min};
         end else if (s_axi_araddr == REG_CODE) begin
            s_axi_rdata <= {10'h0, code_word};
         end else if (s_axi_araddr == REG_CODE_OUT) begin
            s_axi_rdata <= {14'h0, code_res.corrected, code_res.fatal, code_res.data};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // a refused write never opens the busy window
   property p_refuse;
      @(posedge aclk) disable iff (!aresetn)
      (state == S_IDLE && start_write && !cfg_mode) |=> (wr_refused && state == S_IDLE);
   endproperty
   a_refuse: assert property (p_refuse) else $error("write outside session accepted"); // see R2

   // keys only change openness at session entry
   property p_lock_hold;
      @(posedge aclk) disable iff (!aresetn)
      (cfg_mode && !enter_cfg) |=> $stable(blk1_open) && $stable(blk2_open);
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock changed mid session"); // see R6

   // entry with delivered key opens block one
   property p_key1;
      @(posedge aclk) disable iff (!aresetn)
      (enter_cfg && !cfg_mode && state == S_IDLE) |=>
         (blk1_open == (mem[BLK1_KEY] == BLK1_UNLOCK));
   endproperty
   a_key1: assert property (p_key1) else $error("block one key misjudged"); // see R5

   // trim valid follows two cycles after reset release
   property p_trim;
      @(posedge aclk) disable iff (!aresetn)
      (state == S_TRIM) |=> trim_valid && state == S_IDLE;
   endproperty
   a_trim: assert property (p_trim) else $error("trim not loaded"); // see R15

   // fatal code error raises reset request next cycle
   property p_ecc;
      @(posedge aclk) disable iff (!aresetn)
      code_res.fatal |=> ecc_reset_req;
   endproperty
   a_ecc: assert property (p_ecc) else $error("double error not reported"); // see R14

   // signature walk starts from all ones
   property p_sig_init;
      @(posedge aclk) disable iff (!aresetn)
      (state == S_IDLE && start_sig && !start_write) |=> (sig == SIG_INIT && state == S_SIG);
   endproperty
   a_sig_init: assert property (p_sig_init) else $error("signature not preset"); // see R8
   // signature step: taps 15,14,12,3 as a mask, shift left, xor the word
   property p_sig_step;
      @(posedge aclk) disable iff (!aresetn)
      (state == S_SIG) |=> sig == ({$past(sig[14:0]), ^($past(sig) & 16'hd008)} ^
                                   $past(mem[sig_ptr]));
   endproperty
   a_sig_step: assert property (p_sig_step) else $error("signature step wrong"); // see R10
   // block one walk ends at its key within nine steps
   property p_walk;
      @(posedge aclk) disable iff (!aresetn)
      (state == S_IDLE && start_sig && !start_write && !sig_blk) |=> ##[1:9] state == S_IDLE;
   endproperty
   a_walk: assert property (p_walk) else $error("walk overran"); // see R9

   // a write stays busy for at least three cycles
   property p_busy;
      @(posedge aclk) disable iff (!aresetn)
      $rose(state == S_WRITE) |-> (state == S_WRITE) [*3];
   endproperty
   a_busy: assert property (p_busy) else $error("write ended early"); // see R17
endmodule

/* File: design/unused_placeholder_none.sv */
// intentionally empty

/* File: bench/nvm_programmer.sv */
// bus-side programmer model: one write and one read at a time
module nvm_programmer
   import nvm_cfg_pkg::*;
(
   input wire logic aclk, // bus clock
   output logic [7:0] s_axi_awaddr, // write address
   output logic s_axi_awvalid, // write address valid
   input wire logic s_axi_awready, // write address taken
   output logic [31:0] s_axi_wdata, // write data
   output logic s_axi_wvalid, // write data valid
   input wire logic s_axi_wready, // write data taken
   input wire logic [1:0] s_axi_bresp, // write response
   input wire logic s_axi_bvalid, // response valid
   output logic s_axi_bready, // response accepted
   output logic [7:0] s_axi_araddr, // read address
   output logic s_axi_arvalid, // read address valid
   input wire logic s_axi_arready, // read address taken
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic [1:0] s_axi_rresp, // read response
   input wire logic s_axi_rvalid, // read data valid
   output logic s_axi_rready // read data accepted
);
   timeunit 1ns;
   timeprecision 1ns;
   // bus idle from time zero
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 200; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            return;
         end
      end
      tb.n_mismatch++;
      tb.end_sim();
   endtask
   // read address dropped once taken, rready held until data returns
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 200; n++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            return;
         end
      end
      tb.n_mismatch++;
      tb.end_sim();
   endtask
endmodule

/* File: bench/tb.sv */
// scenario bench for the locked, checksummed configuration memory
module tb
   import nvm_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0; // 10 MHz clock
   logic aresetn = 1'b0; // held low at start
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] osc_trim; // trim seen at pins
   logic trim_valid, ecc_reset_req; // status pins
   logic [15:0] img [0:127]; // expected memory image
   int n_mismatch = 0;
   int n_compared = 0;
   always #50 aclk = ~aclk;
   // short write wait keeps the run small
   config_nvm_lock_crc #(.WRITE_WAIT(4)) config_nvm_lock_crc_inst (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .osc_trim, .trim_valid, .ecc_reset_req);
   nvm_programmer nvm_programmer_inst (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one compare for every value kind, widened to a word
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      nvm_programmer_inst.wr(a, d, r);
      chk("bresp", 32'(RESP_OKAY), 32'(r));
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      logic [1:0] r;
      nvm_programmer_inst.rd(a, d, r);
      chk("rresp", 32'(RESP_OKAY), 32'(r));
   endtask
   // a word write takes long: poll busy under a bound
   task automatic cmd(input logic [31:0] c);
      logic [31:0] s;
      reg_wr(REG_CTRL, c);
      for (int n = 0; n < 50; n++) begin
         reg_rd(REG_STATUS, s);
         if (s[1] === 1'b0) return;
      end
      n_mismatch++;
      end_sim();
   endtask
   task automatic mem_wr(input logic [6:0] a, input logic [15:0] d);
      reg_wr(REG_ADDR, 32'(a));
      reg_wr(REG_WDATA, 32'(d));
      cmd(32'h4);
   endtask
   task automatic mem_rd(input logic [6:0] a, output logic [31:0] d);
      reg_wr(REG_ADDR, 32'(a));
      cmd(32'h8);
      reg_rd(REG_RDATA, d);
      d = 32'(d[15:0]);
   endtask
   // signature over first..key of a block from the bench image
   function automatic logic [15:0] sig_of(input logic [6:0] first, input logic [6:0] key);
      logic [15:0] s;
      s = 16'hffff;
      for (int a = first; a <= key; a++) begin
         s = {s[14:0], s[15] ^ s[14] ^ s[12] ^ s[3]} ^ img[a];
      end
      return s;
   endfunction
   // hamming positions 1..21, data in non power-of-two slots, even parity
   function automatic logic [21:0] enc(input logic [15:0] d);
      logic [21:0] c;
      int k;
      c = '0;
      k = 0;
      for (int p = 1; p <= 21; p++) if ((p & (p - 1)) != 0) begin
         c[p-1] = d[k];
         k++;
      end
      for (int b = 0; b < 5; b++) for (int p = 1; p <= 21; p++)
         if (((p >> b) & 1) == 1 && p != (1 << b)) c[(1 << b) - 1] ^= c[p-1];
      c[21] = ^c[20:0];
      return c;
   endfunction
   task automatic put(input logic [6:0] a, input logic [15:0] d);
      img[a] = d;
      mem_wr(a, d);
   endtask
   task automatic t_outside();
      logic [31:0] s;
      logic [1:0] r;
      chk("trim_valid", 32'h1, 32'(trim_valid));
      chk("ecc_reset_req", 32'h0, 32'(ecc_reset_req));
      mem_wr(7'h01, 16'h1111);
      reg_rd(REG_STATUS, s);
      chk("refused outside", 32'h2, 32'({s[5], s[0]}));
      nvm_programmer_inst.rd(8'h40, s, r);
      chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
      chk("unmapped data", 32'h0, s);
   endtask
   task automatic t_block1();
      logic [31:0] s;
      cmd(32'h1);
      put(BLK1_KEY, BLK1_UNLOCK);
      for (int a = 0; a < 8; a++) put(7'(a), 16'(a * 16'h1357 + 16'h0a0f));
      put(BLK1_SUM, sig_of(BLK1_FIRST, BLK1_KEY));
      cmd(32'h2);
      cmd(32'h1);
      reg_rd(REG_STATUS, s);
      chk("session open", 32'h5, 32'({s[2], s[1], s[0]}));
      cmd(32'h10);
      reg_rd(REG_SIG, s);
      chk("sig block one", 32'(sig_of(BLK1_FIRST, BLK1_KEY)), s);
      reg_rd(REG_STATUS, s);
      chk("sig match one", 32'h1, 32'(s[4]));
      for (int a = 0; a < 10; a++) begin
         mem_rd(7'(a), s);
         chk("word block one", 32'(img[a]), s);
      end
   endtask
   task automatic t_lock();
      logic [31:0] s;
      put(BLK1_KEY, 16'h1234);
      put(7'h00, 16'habcd);
      mem_rd(7'h00, s);
      chk("write after lock", 32'h0000abcd, s);
      put(BLK1_SUM, sig_of(BLK1_FIRST, BLK1_KEY));
      cmd(32'h2);
      cmd(32'h1);
      reg_rd(REG_STATUS, s);
      chk("block one shut", 32'h0, 32'(s[2]));
      mem_wr(7'h00, 16'h0f0f);
      reg_rd(REG_STATUS, s);
      chk("locked refused", 32'h1, 32'(s[5]));
      mem_rd(7'h00, s);
      chk("locked kept", 32'h0000abcd, s);
      cmd(32'h10);
      reg_rd(REG_STATUS, s);
      chk("sig match locked", 32'h1, 32'(s[4]));
   endtask
   task automatic t_block2();
      logic [31:0] s;
      limit_pair_t lp;
      put(BLK2_KEY, BLK2_UNLOCK);
      for (int a = 10; a < 116; a++) put(7'(a), 16'(a * 16'h0101 ^ 16'h3c00));
      put(TRIM_ADDR, 16'h7fc6);
      put(7'h45, 16'he613);
      put(BLK2_SUM, sig_of(BLK2_FIRST, BLK2_KEY));
      cmd(32'h30);
      reg_rd(REG_SIG, s);
      chk("sig block two", 32'(sig_of(BLK2_FIRST, BLK2_KEY)), s);
      reg_rd(REG_STATUS, s);
      chk("sig match two", 32'h1, 32'(s[4]));
      mem_rd(7'h45, s);
      lp.max = 8'he6;
      lp.min = 8'h13;
      reg_rd(REG_LIMITS, s);
      chk("limits", 32'(lp), s);
      mem_wr(7'h76, 16'h5555);
      reg_rd(REG_STATUS, s);
      chk("no block refused", 32'h1, 32'(s[5]));
   endtask
   // second reset mid-run: memory keeps its words, trim reloads
   task automatic t_trim();
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      for (int n = 0; n < 20 && trim_valid !== 1'b1; n++) @(posedge aclk);
      chk("trim_valid", 32'h1, 32'(trim_valid));
      chk("osc_trim", 32'hc6, 32'(osc_trim));
   endtask
   task automatic t_ecc();
      logic [31:0] s;
      reg_wr(REG_CODE, 32'(enc(16'h1234)));
      reg_rd(REG_CODE_OUT, s);
      chk("code clean", 32'h00001234, s);
      reg_wr(REG_CODE, 32'(enc(16'hbeef) ^ 22'h000020));
      reg_rd(REG_CODE_OUT, s);
      chk("code one bit", 32'h0002beef, s);
      chk("no reset yet", 32'h0, 32'(ecc_reset_req));
      reg_wr(REG_CODE, 32'(enc(16'hbeef) ^ 22'h000101));
      for (int n = 0; n < 10 && ecc_reset_req !== 1'b1; n++) @(posedge aclk);
      chk("two bit reset", 32'h1, 32'(ecc_reset_req));
   endtask
   // main sequence: reset, then each scenario in turn
   initial begin
      foreach (img[a]) img[a] = 16'h0000; // delivered image, both keys open
      img[BLK1_KEY] = BLK1_UNLOCK;
      img[BLK2_KEY] = BLK2_UNLOCK;
      config_nvm_lock_crc_inst.mem = img;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      t_outside();
      t_block1();
      t_lock();
      t_block2();
      t_trim();
      t_ecc();
      end_sim();
   end
endmodule
